// >>> inc/pirqc_defines.vh
// Constants for the prioritized interrupt controller.
// Assumes one clock domain and plain-port register access from the core.
`ifndef PIRQC_DEFINES_VH
`define PIRQC_DEFINES_VH
`define PIRQC_SCS_BASE 32'hE000E000
`define PIRQC_OFS_SETENA 12'h100
`define PIRQC_OFS_CLRENA 12'h180
`define PIRQC_OFS_SETPEND 12'h200
`define PIRQC_OFS_CLRPEND 12'h280
`define PIRQC_OFS_PRIO0 12'h400
`define PIRQC_OFS_PRIO3 12'h40C
`define PIRQC_PRIO_MSB 7
`define PIRQC_PRIO_LSB 6
`define PIRQC_RST_PRIO 2'h0
`define PIRQC_VTOR_BASE 32'h00000000
`define PIRQC_VEC_RESET 6'h01
`define PIRQC_VEC_NMI 6'h02
`define PIRQC_VEC_HARDFAULT 6'h03
`define PIRQC_VEC_SVC 6'h0B
`define PIRQC_VEC_PENDABLE 6'h0E
`define PIRQC_VEC_TICK 6'h0F
`define PIRQC_VEC_IRQ0 6'h10
`define PIRQC_VEC_NONE 6'h00
`define PIRQC_RANK_RESET 3'h0
`define PIRQC_RANK_NMI 3'h1
`define PIRQC_RANK_HARDFAULT 3'h2
`define PIRQC_RANK_IDLE 3'h7
`define PIRQC_STACK_WORDS 4'h8
`endif

// >>> verilog/pirqc_core.v
// Prioritized interrupt controller: pending, enable, priority, active
// tracking, arbitration and the entry/exit sequencer for stacking.
// Assumes the core performs the bus cycles named by the stack strobes and
// that irq_in, nmi_in and hardfault_in are asynchronous to ref_clk; svc_req, pendable_req and tick_req are used unsynchronised.
`timescale 1ns/1ps
`include "pirqc_defines.vh"
module pirqc_core (
   ref_clk,
   srst,
   irq_in,
   nmi_in,
   hardfault_in,
   svc_req,
   pendable_req,
   tick_req,
   sys_prio_svc,
   sys_prio_pendable,
   sys_prio_tick,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata,
   stack_req,
   stack_push,
   stack_index,
   stack_done,
   vec_fetch,
   vec_addr,
   vec_done,
   exc_return,
   handler_mode,
   active_vector,
   preempt,
   tail_chain
);
   input wire ref_clk;
   input wire srst;
   input wire [15:0] irq_in;
   input wire nmi_in;
   input wire hardfault_in;
   input wire svc_req;
   input wire pendable_req;
   input wire tick_req;
   input wire [1:0] sys_prio_svc;
   input wire [1:0] sys_prio_pendable;
   input wire [1:0] sys_prio_tick;
   input wire reg_wr;
   input wire reg_rd;
   input wire [11:0] reg_addr;
   input wire [31:0] reg_wdata;
   output reg [31:0] reg_rdata;
   output wire stack_req;
   output wire stack_push;
   output wire [3:0] stack_index;
   input wire stack_done;
   output wire vec_fetch;
   output wire [31:0] vec_addr;
   input wire vec_done;
   input wire exc_return;
   output wire handler_mode;
   output wire [5:0] active_vector;
   output reg preempt;
   output reg tail_chain;

   // =========================================================
   // Sequencer states
   localparam ST_THREAD = 3'h0;
   localparam ST_STACK = 3'h1;
   localparam ST_FETCH = 3'h2;
   localparam ST_HANDLER = 3'h3;
   localparam ST_UNSTACK = 3'h4;

   // Rank: lower is more urgent; 3..6 are configurable levels 0..3
   function [2:0] pirqc_rank;
      input [1:0] prio;
      begin
         pirqc_rank = {1'b0, prio} + 3'h3;
      end
   endfunction

   // =========================================================
   // Input synchronisers
   reg [17:0] sync1_ff;
   reg [17:0] sync2_ff;
   reg [17:0] prev_ff;
   always @(posedge ref_clk) begin
      if (srst) begin
         sync1_ff <= 18'h0;
         sync2_ff <= 18'h0;
         prev_ff <= 18'h0;
      end else begin
         sync1_ff <= {hardfault_in, nmi_in, irq_in};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end
   wire [15:0] irq_rise = sync2_ff[15:0] & ~prev_ff[15:0];
   wire nmi_rise = sync2_ff[16] & ~prev_ff[16];
   wire hf_rise = sync2_ff[17] & ~prev_ff[17];

   // =========================================================
   // Register state
   reg [15:0] enable_ff;
   reg [15:0] pend_ff;
   reg [15:0] act_ff;
   reg [1:0] prio_ff [0:15];
   reg [2:0] sys_pend_ff; // svc, pendable, tick
   reg nmi_pend_ff;
   reg hf_pend_ff;
   reg nmi_act_ff;
   reg hf_act_ff;
   reg [2:0] sys_act_ff;

   wire wr_setena = reg_wr && (reg_addr == `PIRQC_OFS_SETENA);
   wire wr_clrena = reg_wr && (reg_addr == `PIRQC_OFS_CLRENA);
   wire wr_setpend = reg_wr && (reg_addr == `PIRQC_OFS_SETPEND);
   wire wr_clrpend = reg_wr && (reg_addr == `PIRQC_OFS_CLRPEND);
   wire wr_prio = reg_wr && (reg_addr >= `PIRQC_OFS_PRIO0) &&
      (reg_addr <= `PIRQC_OFS_PRIO3) && (reg_addr[1:0] == 2'h0);
   wire [1:0] prio_word = reg_addr[3:2];

   // =========================================================
   // Arbitration
   reg [2:0] best_rank;
   reg [5:0] best_vec;
   reg [2:0] cur_rank;
   integer i;
   integer j;
   always @* begin
      best_rank = `PIRQC_RANK_IDLE;
      best_vec = `PIRQC_VEC_NONE;
      // Lowest number wins among equal ranks
      for (i = 15; i >= 0; i = i - 1) begin
         if (pend_ff[i] && enable_ff[i] && !act_ff[i] &&
               pirqc_rank(prio_ff[i]) <= best_rank) begin
            best_rank = pirqc_rank(prio_ff[i]);
            best_vec = `PIRQC_VEC_IRQ0 + i[5:0];
         end
      end
      if (sys_pend_ff[2] && !sys_act_ff[2] && pirqc_rank(sys_prio_tick) <= best_rank) begin
         best_rank = pirqc_rank(sys_prio_tick);
         best_vec = `PIRQC_VEC_TICK;
      end
      if (sys_pend_ff[1] && !sys_act_ff[1] && pirqc_rank(sys_prio_pendable) <= best_rank) begin
         best_rank = pirqc_rank(sys_prio_pendable);
         best_vec = `PIRQC_VEC_PENDABLE;
      end
      if (sys_pend_ff[0] && !sys_act_ff[0] && pirqc_rank(sys_prio_svc) <= best_rank) begin
         best_rank = pirqc_rank(sys_prio_svc);
         best_vec = `PIRQC_VEC_SVC;
      end
      if (hf_pend_ff && !hf_act_ff) begin
         best_rank = `PIRQC_RANK_HARDFAULT;
         best_vec = `PIRQC_VEC_HARDFAULT;
      end
      if (nmi_pend_ff && !nmi_act_ff) begin
         best_rank = `PIRQC_RANK_NMI;
         best_vec = `PIRQC_VEC_NMI;
      end
      // Running priority: most urgent active exception
      cur_rank = `PIRQC_RANK_IDLE;
      for (i = 15; i >= 0; i = i - 1) begin
         if (act_ff[i] && pirqc_rank(prio_ff[i]) < cur_rank) begin
            cur_rank = pirqc_rank(prio_ff[i]);
         end
      end
      if (sys_act_ff[2] && pirqc_rank(sys_prio_tick) < cur_rank)
         cur_rank = pirqc_rank(sys_prio_tick);
      if (sys_act_ff[1] && pirqc_rank(sys_prio_pendable) < cur_rank)
         cur_rank = pirqc_rank(sys_prio_pendable);
      if (sys_act_ff[0] && pirqc_rank(sys_prio_svc) < cur_rank)
         cur_rank = pirqc_rank(sys_prio_svc);
      if (hf_act_ff)
         cur_rank = `PIRQC_RANK_HARDFAULT;
      if (nmi_act_ff)
         cur_rank = `PIRQC_RANK_NMI;
   end

   wire take_new = (best_rank < cur_rank);

   // =========================================================
   // Entry/exit sequencer
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [3:0] cnt_ff;
   reg [5:0] sel_vec_ff;
   reg [2:0] sel_rank_ff;
   reg [5:0] run_vec_ff;
   reg [5:0] stk_vec_ff [0:7];
   reg [2:0] depth_ff;
   reg [2:0] cur_rank_below;
   reg chained_ff;
   wire activate = (state_ff == ST_FETCH) && vec_done;
   wire [2:0] depth_m1 = depth_ff - 3'h1;
   wire leave = (state_ff == ST_HANDLER) && exc_return;

   // Running rank after the current handler leaves
   always @* begin
      cur_rank_below = `PIRQC_RANK_IDLE;
      if (depth_ff > 3'h1)
         cur_rank_below = vec_rank(stk_vec_ff[depth_ff - 3'h2]);
   end
   wire chain = leave && (best_rank < cur_rank_below);

   function [2:0] vec_rank;
      input [5:0] v;
      begin
         case (v)
            `PIRQC_VEC_NMI: vec_rank = `PIRQC_RANK_NMI;
            `PIRQC_VEC_HARDFAULT: vec_rank = `PIRQC_RANK_HARDFAULT;
            `PIRQC_VEC_SVC: vec_rank = pirqc_rank(sys_prio_svc);
            `PIRQC_VEC_PENDABLE: vec_rank = pirqc_rank(sys_prio_pendable);
            `PIRQC_VEC_TICK: vec_rank = pirqc_rank(sys_prio_tick);
            default: vec_rank = (v >= `PIRQC_VEC_IRQ0) ?
               pirqc_rank(prio_ff[v[3:0]]) : `PIRQC_RANK_IDLE;
         endcase
      end
   endfunction

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_THREAD: if (take_new) nxt_state = ST_STACK;
         ST_STACK: if (stack_done && cnt_ff == `PIRQC_STACK_WORDS - 4'h1)
            nxt_state = ST_FETCH;
         ST_FETCH: if (vec_done) nxt_state = ST_HANDLER;
         ST_HANDLER: begin
            if (chain)
               nxt_state = ST_FETCH;
            else if (leave)
               nxt_state = ST_UNSTACK;
            else if (take_new)
               nxt_state = ST_STACK;
         end
         ST_UNSTACK: if (stack_done && cnt_ff == `PIRQC_STACK_WORDS - 4'h1)
            nxt_state = (depth_ff == 3'h0) ? ST_THREAD : ST_HANDLER;
         default: nxt_state = ST_THREAD;
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         state_ff <= ST_THREAD;
         cnt_ff <= 4'h0;
         sel_vec_ff <= `PIRQC_VEC_NONE;
         sel_rank_ff <= `PIRQC_RANK_IDLE;
         run_vec_ff <= `PIRQC_VEC_NONE;
         depth_ff <= 3'h0;
         preempt <= 1'b0;
         tail_chain <= 1'b0;
         chained_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         preempt <= (state_ff == ST_HANDLER) && take_new && !leave;
         tail_chain <= chain;
         chained_ff <= chain || (chained_ff && !activate);
         if (nxt_state != state_ff)
            cnt_ff <= 4'h0;
         else if (stack_done)
            cnt_ff <= cnt_ff + 4'h1;
         // Late arrival: retarget while stacking or fetching
         if (((state_ff == ST_THREAD || state_ff == ST_HANDLER) && take_new) || chain ||
               ((state_ff == ST_STACK || state_ff == ST_FETCH) && !vec_done &&
               best_rank < sel_rank_ff)) begin
            sel_vec_ff <= best_vec;
            sel_rank_ff <= best_rank;
         end
         // Chained entry reuses the frame; depth stays put
         if (activate) begin
            stk_vec_ff[chained_ff ? depth_m1 : depth_ff] <= sel_vec_ff;
            depth_ff <= chained_ff ? depth_ff : depth_ff + 3'h1;
            run_vec_ff <= sel_vec_ff;
         end else if (leave && !chain) begin
            depth_ff <= depth_m1;
            run_vec_ff <= (depth_ff > 3'h1) ? stk_vec_ff[depth_ff - 3'h2] : `PIRQC_VEC_NONE;
         end
      end
   end
   // =========================================================
   // Pending, enable, active, priority
   wire [5:0] done_vec = run_vec_ff;
   always @(posedge ref_clk) begin
      if (srst) begin
         enable_ff <= 16'h0;
         pend_ff <= 16'h0;
         act_ff <= 16'h0;
         sys_pend_ff <= 3'h0;
         sys_act_ff <= 3'h0;
         nmi_pend_ff <= 1'b0;
         hf_pend_ff <= 1'b0;
         nmi_act_ff <= 1'b0;
         hf_act_ff <= 1'b0;
         for (j = 0; j < 16; j = j + 1)
            prio_ff[j] <= `PIRQC_RST_PRIO;
      end else begin
         if (wr_setena)
            enable_ff <= enable_ff | reg_wdata[15:0];
         else if (wr_clrena)
            enable_ff <= enable_ff & ~reg_wdata[15:0];
         // Hardware set wins over clear; activation clears
         pend_ff <= ((pend_ff & ~({16{wr_clrpend}} & reg_wdata[15:0]))
            & ~((activate && sel_vec_ff >= `PIRQC_VEC_IRQ0) ?
               (16'h1 << sel_vec_ff[3:0]) : 16'h0))
            | irq_rise | ({16{wr_setpend}} & reg_wdata[15:0]);
         sys_pend_ff <= (sys_pend_ff & ~{
            activate && sel_vec_ff == `PIRQC_VEC_TICK,
            activate && sel_vec_ff == `PIRQC_VEC_PENDABLE,
            activate && sel_vec_ff == `PIRQC_VEC_SVC})
            | {tick_req, pendable_req, svc_req};
         nmi_pend_ff <= (nmi_pend_ff & ~(activate && sel_vec_ff == `PIRQC_VEC_NMI)) | nmi_rise;
         hf_pend_ff <= (hf_pend_ff & ~(activate && sel_vec_ff == `PIRQC_VEC_HARDFAULT)) | hf_rise;
         // Active cleared only on exception return
         if (activate) begin
            if (sel_vec_ff >= `PIRQC_VEC_IRQ0) act_ff[sel_vec_ff[3:0]] <= 1'b1;
            if (sel_vec_ff == `PIRQC_VEC_NMI) nmi_act_ff <= 1'b1;
            if (sel_vec_ff == `PIRQC_VEC_HARDFAULT) hf_act_ff <= 1'b1;
            if (sel_vec_ff == `PIRQC_VEC_SVC) sys_act_ff[0] <= 1'b1;
            if (sel_vec_ff == `PIRQC_VEC_PENDABLE) sys_act_ff[1] <= 1'b1;
            if (sel_vec_ff == `PIRQC_VEC_TICK) sys_act_ff[2] <= 1'b1;
         end
         if (leave) begin
            if (done_vec >= `PIRQC_VEC_IRQ0) act_ff[done_vec[3:0]] <= 1'b0;
            if (done_vec == `PIRQC_VEC_NMI) nmi_act_ff <= 1'b0;
            if (done_vec == `PIRQC_VEC_HARDFAULT) hf_act_ff <= 1'b0;
            if (done_vec == `PIRQC_VEC_SVC) sys_act_ff[0] <= 1'b0;
            if (done_vec == `PIRQC_VEC_PENDABLE) sys_act_ff[1] <= 1'b0;
            if (done_vec == `PIRQC_VEC_TICK) sys_act_ff[2] <= 1'b0;
         end
         if (wr_prio) begin
            prio_ff[{prio_word, 2'h0}] <= reg_wdata[`PIRQC_PRIO_MSB:`PIRQC_PRIO_LSB];
            prio_ff[{prio_word, 2'h1}] <= reg_wdata[15:14];
            prio_ff[{prio_word, 2'h2}] <= reg_wdata[23:22];
            prio_ff[{prio_word, 2'h3}] <= reg_wdata[31:30];
         end
      end
   end

   // =========================================================
   // Read data
   always @(posedge ref_clk) begin
      if (srst)
         reg_rdata <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            `PIRQC_OFS_SETENA, `PIRQC_OFS_CLRENA: reg_rdata <= {16'h0, enable_ff};
            `PIRQC_OFS_SETPEND, `PIRQC_OFS_CLRPEND: reg_rdata <= {16'h0, pend_ff};
            default: reg_rdata <= (reg_addr >= `PIRQC_OFS_PRIO0 && reg_addr <= `PIRQC_OFS_PRIO3) ?
               {prio_ff[{prio_word, 2'h3}], 6'h0, prio_ff[{prio_word, 2'h2}], 6'h0,
                prio_ff[{prio_word, 2'h1}], 6'h0, prio_ff[{prio_word, 2'h0}], 6'h0} : 32'h0;
         endcase
      end
   end

   // =========================================================
   // Outputs
   assign stack_req = (state_ff == ST_STACK) || (state_ff == ST_UNSTACK);
   assign stack_push = (state_ff == ST_STACK);
   assign stack_index = cnt_ff;
   assign vec_fetch = (state_ff == ST_FETCH) || (state_ff == ST_STACK);
   assign vec_addr = `PIRQC_VTOR_BASE + {24'h0, sel_vec_ff, 2'h0};
   assign handler_mode = (depth_ff != 3'h0) || chained_ff;
   assign active_vector = run_vec_ff;
   // Source order 0 watchdog_irq ... 14 wakeup_irq, 15 reserved
endmodule // pirqc_core

// >>> test/pirqc_checker.sv
// Port checker for the interrupt controller core.
// Assumes one clock ref_clk and synchronous active-high srst.
`timescale 1ns/1ps
// ==========================================================
// Checker
module pirqc_checker (
   input wire ref_clk,
   input wire srst,
   input wire [31:0] reg_rdata,
   input wire stack_req,
   input wire stack_push,
   input wire [3:0] stack_index,
   input wire stack_done,
   input wire vec_fetch,
   input wire [31:0] vec_addr,
   input wire vec_done,
   input wire handler_mode,
   input wire [5:0] active_vector,
   input wire preempt,
   input wire tail_chain
);
   reg [3:0] words_ff;
   wire [3:0] nxt_words = stack_req ? words_ff + {3'h0, stack_done} : 4'h0;
   always @(posedge ref_clk) begin
      words_ff <= srst ? 4'h0 : nxt_words;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   words_eight_a: assert property ($fell(stack_req) |-> words_ff == 4'h8)
      else $error("stack transfer not eight words");
   index_count_a: assert property (stack_req |-> stack_index == words_ff)
      else $error("stack index out of step");
   push_fetch_a: assert property ($rose(stack_req) && stack_push |-> vec_fetch)
      else $error("push without vector fetch");
   vec_table_a: assert property (vec_fetch |-> vec_addr[31:7] == 25'h0 && vec_addr[1:0] == 2'h0)
      else $error("vector address off table");
   mode_match_a: assert property (handler_mode == (active_vector != 6'h00))
      else $error("handler mode and vector disagree");
   vec_legal_a: assert property (handler_mode |-> active_vector inside {6'h01, 6'h02, 6'h03,
      6'h0B, 6'h0E, 6'h0F, [6'h10:6'h1F]})
      else $error("reserved vector active");
   enter_mode_a: assert property (vec_done && vec_fetch |-> ##[1:2] handler_mode)
      else $error("no handler mode after fetch");
   tail_skip_a: assert property (tail_chain |-> !stack_req ##[0:2] (vec_fetch && !stack_req))
      else $error("tail chain stacked");
   preempt_nest_a: assert property (preempt |-> handler_mode)
      else $error("preempt outside handler");
   reset_clear_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 32'h0 && !stack_req && !handler_mode)
      else $error("state not cleared by reset");
endmodule // pirqc_checker
bind pirqc_core pirqc_checker pirqc_checker_i (.ref_clk(ref_clk), .srst(srst),
   .reg_rdata(reg_rdata), .stack_req(stack_req), .stack_push(stack_push),
   .stack_index(stack_index),
   .stack_done(stack_done), .vec_fetch(vec_fetch), .vec_addr(vec_addr), .vec_done(vec_done),
   .handler_mode(handler_mode), .active_vector(active_vector), .preempt(preempt),
   .tail_chain(tail_chain));

// >>> test/pirqc_core_model.sv
// Behavioural core side: answers stack words and vector fetches.
// Assumes the controller holds its strobes until answered.
`timescale 1ns/1ps
// ==========================================================
// Core model
module pirqc_core_model (
   input wire ref_clk,
   input wire srst,
   input wire slow,
   input wire stack_req,
   input wire stack_push,
   input wire vec_fetch,
   output reg stack_done,
   output reg vec_done,
   output int n_push,
   output int n_pop
);
   reg [2:0] wait_ff;
   always @(posedge ref_clk) begin
      stack_done <= 1'b0;
      vec_done <= 1'b0;
      if (srst) begin
         wait_ff <= 3'h0;
         n_push <= 0;
         n_pop <= 0;
      end else if ((stack_req || vec_fetch) && !stack_done && !vec_done) begin
         if (wait_ff >= (slow ? 3'h6 : 3'h1)) begin
            wait_ff <= 3'h0;
            if (stack_req) stack_done <= 1'b1;
            else vec_done <= 1'b1;
         end else begin
            wait_ff <= wait_ff + 3'h1;
         end
      end else begin
         wait_ff <= 3'h0;
      end
      if (!srst && stack_done && stack_req) begin
         if (stack_push) n_push <= n_push + 1;
         else n_pop <= n_pop + 1;
      end
   end
endmodule // pirqc_core_model

// >>> test/pirqc_core_bench.sv
// Self-checking bench for the interrupt controller core.
// Assumes the core model beside it and a 40 MHz ref_clk.
`timescale 1ns/1ps
// ==========================================================
// Bench
module pirqc_core_bench;
   reg ref_clk, srst, reg_wr, reg_rd, exc_return, slow;
   reg [15:0] irq_in;
   reg [4:0] sys;
   reg [11:0] reg_addr;
   reg [31:0] reg_wdata, last_va;
   wire [31:0] reg_rdata, vec_addr;
   wire stack_req, stack_push, stack_done, vec_fetch, vec_done, handler_mode, preempt, tail_chain;
   wire [3:0] stack_index;
   wire [5:0] active_vector;
   int n_push, n_pop, fails, num_checks, cyc, p0, i;
   logic [11:0] offs [0:8] = '{12'h100, 12'h180, 12'h200, 12'h280, 12'h400, 12'h404,
      12'h408, 12'h40C, 12'h300};
   logic [5:0] vecs [0:4] = '{6'h0B, 6'h0E, 6'h0F, 6'h02, 6'h03};
   pirqc_core pirqc_core_i (.ref_clk(ref_clk), .srst(srst), .irq_in(irq_in),
      .nmi_in(sys[3]), .hardfault_in(sys[4]), .svc_req(sys[0]), .pendable_req(sys[1]),
      .tick_req(sys[2]), .sys_prio_svc(2'h1), .sys_prio_pendable(2'h1),
      .sys_prio_tick(2'h1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stack_req(stack_req),
      .stack_push(stack_push), .stack_index(stack_index), .stack_done(stack_done),
      .vec_fetch(vec_fetch), .vec_addr(vec_addr), .vec_done(vec_done),
      .exc_return(exc_return), .handler_mode(handler_mode), .active_vector(active_vector),
      .preempt(preempt), .tail_chain(tail_chain));
   pirqc_core_model pirqc_core_model_i (.ref_clk(ref_clk), .srst(srst), .slow(slow),
      .stack_req(stack_req), .stack_push(stack_push), .vec_fetch(vec_fetch),
      .stack_done(stack_done), .vec_done(vec_done), .n_push(n_push), .n_pop(n_pop));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (vec_done) last_va <= vec_addr;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         stop_test;
      end
   end
   task tick;
      @(posedge ref_clk);
      #2;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      tick;
   endtask
   task rd(input [11:0] a, input [31:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      tick;
      chk("reg_rdata", e, reg_rdata);
   endtask
   task irq(input int n);
      irq_in[n] = 1'b1;
      repeat (3) tick;
      irq_in[n] = 1'b0;
      repeat (3) tick;
   endtask
   task enter(input [5:0] v);
      for (int k = 0; k < 600 && vec_done !== 1'b1; k++) tick;
      tick;
      tick;
      chk("active_vector", {26'h0, v}, {26'h0, active_vector});
      chk("handler_mode", 32'h1, {31'h0, handler_mode});
   endtask
   task leave;
      exc_return = 1'b1;
      tick;
      exc_return = 1'b0;
      tick;
      for (int k = 0; k < 300 && (stack_req | vec_fetch) !== 1'b0; k++) tick;
      tick;
   endtask
   task stop_test;
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {srst, reg_wr, reg_rd, exc_return, slow, irq_in, sys} = {1'b1, 25'h0};
      {reg_addr, reg_wdata, fails, num_checks} = 0;
      repeat (12) tick;
      srst = 1'b0;
      tick;
      foreach (offs[j]) rd(offs[j], 32'h0);
      for (i = 0; i < 4; i++) begin
         wr(12'h400 + 4 * i, 32'hFFFF_FFFF);
         rd(12'h400 + 4 * i, 32'hC0C0_C0C0);
      end
      wr(12'h100, 32'h0000_8005);
      rd(12'h180, 32'h0000_8005);
      wr(12'h180, 32'h0000_0004);
      wr(12'h100, 32'h0);
      rd(12'h100, 32'h0000_8001);
      wr(12'h180, 32'h0000_FFFF);
      irq(3);
      repeat (20) tick;
      chk("handler_mode", 32'h0, {31'h0, handler_mode});
      rd(12'h280, 32'h0000_0008);
      wr(12'h280, 32'h0000_0008);
      wr(12'h200, 32'h0000_0020);
      rd(12'h200, 32'h0000_0020);
      wr(12'h280, 32'h0000_FFFF);
      wr(12'h400, 32'h8000_4000);
      wr(12'h404, 32'hC000_0000);
      wr(12'h100, 32'h0000_00AB);
      p0 = n_push;
      irq(3);
      enter(6'h13);
      chk("vec_addr", 32'h0000_004C, last_va);
      chk("pushes", 8, n_push - p0);
      rd(12'h200, 32'h0);
      wr(12'h180, 32'h0000_0008);
      wr(12'h280, 32'h0000_0008);
      repeat (5) tick;
      chk("active_vector", 32'h13, {26'h0, active_vector});
      wr(12'h200, 32'h0000_0001);
      enter(6'h10);
      wr(12'h200, 32'h0000_0020);
      repeat (30) tick;
      chk("active_vector", 32'h10, {26'h0, active_vector});
      p0 = n_pop;
      leave;
      chk("active_vector", 32'h15, {26'h0, active_vector});
      chk("pops", 0, n_pop - p0);
      leave;
      chk("active_vector", 32'h13, {26'h0, active_vector});
      chk("pops", 8, n_pop - p0);
      leave;
      chk("handler_mode", 32'h0, {31'h0, handler_mode});
      slow = 1'b1;
      p0 = n_push;
      wr(12'h200, 32'h0000_0080);
      for (int k = 0; k < 50 && stack_req !== 1'b1; k++) tick;
      repeat (4) tick;
      wr(12'h200, 32'h0000_0002);
      enter(6'h11);
      chk("pushes", 8, n_push - p0);
      slow = 1'b0;
      leave;
      chk("active_vector", 32'h17, {26'h0, active_vector});
      leave;
      wr(12'h200, 32'h0000_0001);
      enter(6'h10);
      sys[4] = 1'b1;
      tick;
      sys[4] = 1'b0;
      enter(6'h03);
      leave;
      leave;
      for (i = 0; i < 5; i++) begin
         sys[i] = 1'b1;
         tick;
         sys[i] = 1'b0;
         enter(vecs[i]);
         leave;
      end
      srst = 1'b1;
      repeat (2) tick;
      srst = 1'b0;
      tick;
      rd(12'h400, 32'h0);
      rd(12'h100, 32'h0);
      stop_test;
   end
endmodule // pirqc_core_bench
